// [hdl/adc_cmp_pkg.sv]
/*
  constants, register indices and carrier types of the converter
  computation and trigger block.
  assumes a 32-bit axi4-lite register bus, one register per word.
*/
package adc_cmp_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [13:0] IDX_LTH = 14'h1D0C;
  localparam logic [13:0] IDX_UTH = 14'h1D0E;
  localparam logic [13:0] IDX_ERR = 14'h1D10;
  localparam logic [13:0] IDX_STPT = 14'h1D12;
  localparam logic [13:0] IDX_FLT = 14'h1D14;
  localparam logic [13:0] IDX_ACC = 14'h1D16;
  localparam logic [13:0] IDX_CNT = 14'h1D19;
  localparam logic [13:0] IDX_RPT = 14'h1D1A;
  localparam logic [13:0] IDX_PREV = 14'h1D1B;
  localparam logic [13:0] IDX_RES = 14'h1D1D;
  localparam logic [13:0] IDX_PCH = 14'h1D1F;
  localparam logic [13:0] IDX_ACT = 14'h1D2C;
  localparam logic [13:0] IDX_CGA = 14'h1D2E;
  localparam logic [13:0] IDX_CGB = 14'h1D2F;
  localparam logic [13:0] IDX_CGC = 14'h1D30;
  localparam logic [13:0] IDX_CGD = 14'h1D31;
  localparam logic [13:0] IDX_CGE = 14'h1D32;
  localparam logic [13:0] IDX_CTRL = 14'h1D40;
  localparam logic [13:0] IDX_STAT = 14'h1D41;
  // ---------------------------------------------------------------
  // field positions, codes and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_LOW_BIT = 0;
  localparam int STAT_UP_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] ACT_OFF = 5'h00;
  localparam logic [4:0] ACT_PIN = 5'h01;
  localparam logic [4:0] ACT_HW_LAST = 5'h19;
  localparam logic [4:0] ACT_ERR_RD = 5'h1D;
  localparam logic [4:0] ACT_RES_RD = 5'h1E;
  localparam logic [4:0] ACT_PCH_WR = 5'h1F;
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACC = 3'h1;
  localparam logic [2:0] MD_AVG = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF = 3'h4;
  localparam logic [2:0] ERROR_MODE_A_RES_PREV = 3'h0;
  localparam logic [2:0] ERROR_MODE_A_RES_STPT = 3'h1;
  localparam logic [2:0] ERROR_MODE_A_RES_FLT = 3'h2;
  localparam logic [2:0] TMD_NEVER = 3'h0;
  localparam logic [2:0] TMD_BELOW = 3'h1;
  localparam logic [2:0] TMD_ABOVE = 3'h2;
  localparam logic [2:0] TMD_INSIDE = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_NOT_BELOW = 3'h5;
  localparam logic [2:0] TMD_NOT_ABOVE = 3'h6;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] md;
    logic [2:0] accum_shift;
    logic [2:0] threshold_irq_mode;
    logic [2:0] error_mode_a;
    logic [1:0] result_format_mode;
    logic prev_source_select;
    logic enable;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '0;
  typedef struct packed {
    logic [2:0] port_e;
    logic [7:0] port_d;
    logic [7:0] port_c;
    logic [7:0] port_b;
    logic [7:0] port_a;
  } groups_t;
  localparam groups_t GROUPS_RST = '0;
endpackage

// [hdl/adc_cmp_top.sv]
/*
  converter computation, threshold and trigger block with an
  axi4-lite register slave.
  assumes the analog converter outside answers each start pulse with
  one done pulse carrying a 12-bit sample; peripheral trigger inputs
  share the clock, the trigger pin does not.
*/
// Operation
// - select 1: previous result takes filter output at conversion start
// - select 0: previous result takes conversion result at start
// - with select 0 previous keeps the result register's alignment
// - accumulator is 18-bit signed; top-byte spare bits copy the sign
// - accumulator writes act only while go is 0
// - accumulator bytes: upper 17:16, high 15:8, low 7:0
// - setpoint is 16-bit signed RW, resets zero, error operand
// - error is 16-bit signed RO, formula from error mode
// - error compared to thresholds updates below and above flags
// - threshold event raised as the irq mode field selects
// - 5-bit trigger code; 0 disables, 1 selects routed pin
// - codes 31/30/29: channel write, result read, error read
// - codes for logic cells, change flag, comparators, oscillator, pwm
// - timer and capture codes 2..9; codes 26..28 start nothing
// - ports a..d: eight group enable bits each, reset 0
// - port e: only group bits 0..2 exist
// - filter output is accumulator shifted, or low-pass result
// - averaging, burst and low-pass check thresholds when count hits repeat
`timescale 1ns/10ps
`default_nettype none
module adc_cmp_top
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // axi4-lite write
  input wire logic [15:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [15:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // trigger sources, indexed by trigger code
  input wire logic [31:0] I_TRIG_PERIPH,
  input wire logic I_TRIG_PIN,
  // converter
  output logic O_CONV_START,
  input wire logic I_CONV_DONE,
  input wire logic [11:0] I_CONV_DATA,
  // channel selection and events
  output logic [5:0] O_POS_CHANNEL,
  output adc_cmp_pkg::groups_t O_GROUPS,
  output logic O_THRESH_IRQ
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  adc_cmp_pkg::ctrl_t ctrl_q;
  adc_cmp_pkg::groups_t groups_q;
  logic go_q;
  logic [15:0] lth_q, uth_q, stpt_q, err_q, flt_q, res_q, prev_q;
  logic [17:0] acc_q;
  logic [7:0] cnt_q, rpt_q;
  logic [5:0] pch_q;
  logic [4:0] act_q;
  logic below_q, above_q, irq_q;
  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [13:0] aw_idx_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, rd_go, wr_ok, rd_ok;
  logic [13:0] rd_idx;
  logic [31:0] rd_mux;

  assign O_AWREADY = !aw_full_q;
  assign O_WREADY = !w_full_q;
  assign O_ARREADY = !rvalid_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign rd_go = I_ARVALID && !rvalid_q;
  assign rd_idx = I_ARADDR[15:2];

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [13:0] idx);
    case (idx)
      adc_cmp_pkg::IDX_LTH, adc_cmp_pkg::IDX_UTH, adc_cmp_pkg::IDX_ERR,
      adc_cmp_pkg::IDX_STPT, adc_cmp_pkg::IDX_FLT, adc_cmp_pkg::IDX_ACC,
      adc_cmp_pkg::IDX_CNT, adc_cmp_pkg::IDX_RPT, adc_cmp_pkg::IDX_PREV,
      adc_cmp_pkg::IDX_RES, adc_cmp_pkg::IDX_PCH, adc_cmp_pkg::IDX_ACT,
      adc_cmp_pkg::IDX_CGA, adc_cmp_pkg::IDX_CGB, adc_cmp_pkg::IDX_CGC,
      adc_cmp_pkg::IDX_CGD, adc_cmp_pkg::IDX_CGE, adc_cmp_pkg::IDX_CTRL,
      adc_cmp_pkg::IDX_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  assign wr_ok = wr_go && mapped(aw_idx_q);
  assign rd_ok = rd_go && mapped(rd_idx);

  // address and data are taken in either order, answered when both held
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= adc_cmp_pkg::RESP_OKAY;
      aw_idx_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (I_AWVALID && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q <= I_AWADDR[15:2];
      end
      if (I_WVALID && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_go)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? adc_cmp_pkg::RESP_OKAY : adc_cmp_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && I_BREADY)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb
  begin
    rd_mux = '0;
    case (rd_idx)
      adc_cmp_pkg::IDX_LTH: rd_mux[15:0] = lth_q;
      adc_cmp_pkg::IDX_UTH: rd_mux[15:0] = uth_q;
      adc_cmp_pkg::IDX_ERR: rd_mux[15:0] = err_q;
      adc_cmp_pkg::IDX_STPT: rd_mux[15:0] = stpt_q;
      adc_cmp_pkg::IDX_FLT: rd_mux[15:0] = flt_q;
      adc_cmp_pkg::IDX_ACC: rd_mux[23:0] = {{6{acc_q[17]}}, acc_q};
      adc_cmp_pkg::IDX_CNT: rd_mux[7:0] = cnt_q;
      adc_cmp_pkg::IDX_RPT: rd_mux[7:0] = rpt_q;
      adc_cmp_pkg::IDX_PREV: rd_mux[15:0] = prev_q;
      adc_cmp_pkg::IDX_RES: rd_mux[15:0] = res_q;
      adc_cmp_pkg::IDX_PCH: rd_mux[5:0] = pch_q;
      adc_cmp_pkg::IDX_ACT: rd_mux[4:0] = act_q;
      adc_cmp_pkg::IDX_CGA: rd_mux[7:0] = groups_q.port_a;
      adc_cmp_pkg::IDX_CGB: rd_mux[7:0] = groups_q.port_b;
      adc_cmp_pkg::IDX_CGC: rd_mux[7:0] = groups_q.port_c;
      adc_cmp_pkg::IDX_CGD: rd_mux[7:0] = groups_q.port_d;
      adc_cmp_pkg::IDX_CGE: rd_mux[2:0] = groups_q.port_e;
      adc_cmp_pkg::IDX_CTRL: rd_mux[16:0] = {ctrl_q, go_q};
      adc_cmp_pkg::IDX_STAT: rd_mux[2:0] = {go_q, above_q, below_q};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= adc_cmp_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? adc_cmp_pkg::RESP_OKAY : adc_cmp_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && I_RREADY)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] wm;
  logic wr_acc_ok;
  assign wm = merge(32'h0000_0000, wdata_q, wstrb_q);

  function automatic logic [31:0] upd(input logic [31:0] old);
    return merge(old, wdata_q, wstrb_q);
  endfunction

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      lth_q <= adc_cmp_pkg::RST_WORD16;
      uth_q <= adc_cmp_pkg::RST_WORD16;
      stpt_q <= adc_cmp_pkg::RST_WORD16;
      rpt_q <= '0;
      pch_q <= '0;
      act_q <= adc_cmp_pkg::ACT_OFF;
      groups_q <= adc_cmp_pkg::GROUPS_RST;
      ctrl_q <= adc_cmp_pkg::CTRL_RST;
    end
    else if (wr_ok)
    begin
      case (aw_idx_q)
        adc_cmp_pkg::IDX_LTH: lth_q <= 16'(upd({16'h0000, lth_q}));
        adc_cmp_pkg::IDX_UTH: uth_q <= 16'(upd({16'h0000, uth_q}));
        adc_cmp_pkg::IDX_STPT: stpt_q <= 16'(upd({16'h0000, stpt_q}));
        adc_cmp_pkg::IDX_RPT: rpt_q <= 8'(upd({24'h000000, rpt_q}));
        adc_cmp_pkg::IDX_PCH: pch_q <= 6'(upd({26'h0000000, pch_q}));
        adc_cmp_pkg::IDX_ACT: act_q <= 5'(upd({27'h0000000, act_q}));
        adc_cmp_pkg::IDX_CGA: groups_q.port_a <= wm[7:0];
        adc_cmp_pkg::IDX_CGB: groups_q.port_b <= wm[7:0];
        adc_cmp_pkg::IDX_CGC: groups_q.port_c <= wm[7:0];
        adc_cmp_pkg::IDX_CGD: groups_q.port_d <= wm[7:0];
        adc_cmp_pkg::IDX_CGE: groups_q.port_e <= wm[2:0];
        adc_cmp_pkg::IDX_CTRL:
          ctrl_q <= 16'(upd({15'h0000, ctrl_q, go_q}) >> 1);
        default: ;
      endcase
    end
  end
  assign O_POS_CHANNEL = pch_q;
  assign O_GROUPS = groups_q;

  // ---------------------------------------------------------------
  // trigger selection and conversion start
  // ---------------------------------------------------------------
  logic pin_s1_q, pin_s2_q, src_q, hw_src, sw_trig, trig, start;
  logic go_wr, go_wdata;
  assign go_wr = wr_ok && aw_idx_q == adc_cmp_pkg::IDX_CTRL && wstrb_q[0];
  assign go_wdata = wdata_q[adc_cmp_pkg::CTRL_GO_BIT];

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      src_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= I_TRIG_PIN;
      pin_s2_q <= pin_s1_q;
      src_q <= hw_src;
    end
  end

  always_comb
  begin
    hw_src = 1'b0;
    if (act_q == adc_cmp_pkg::ACT_PIN)
    begin
      hw_src = pin_s2_q;
    end
    else if (act_q != adc_cmp_pkg::ACT_OFF
      && act_q <= adc_cmp_pkg::ACT_HW_LAST)
    begin
      hw_src = I_TRIG_PERIPH[act_q];
    end
  end

  always_comb
  begin
    case (act_q)
      adc_cmp_pkg::ACT_PCH_WR:
        sw_trig = wr_ok && aw_idx_q == adc_cmp_pkg::IDX_PCH;
      adc_cmp_pkg::ACT_RES_RD:
        sw_trig = rd_ok && rd_idx == adc_cmp_pkg::IDX_RES;
      adc_cmp_pkg::ACT_ERR_RD:
        sw_trig = rd_ok && rd_idx == adc_cmp_pkg::IDX_ERR;
      default: sw_trig = 1'b0; // reserved codes start nothing
    endcase
  end

  assign trig = ctrl_q.enable && ((hw_src && !src_q) || sw_trig);
  assign start = !go_q && ctrl_q.enable && (trig || (go_wr && go_wdata));
  assign O_CONV_START = start;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      go_q <= 1'b0;
    end
    else if (start)
    begin
      go_q <= 1'b1;
    end
    else if (I_CONV_DONE || (go_wr && !go_wdata))
    begin
      go_q <= 1'b0;
    end
  end

  // previous result captured as the conversion begins
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      prev_q <= adc_cmp_pkg::RST_WORD16;
    end
    else if (start)
    begin
      prev_q <= ctrl_q.prev_source_select ? flt_q : res_q;
    end
  end

  // ---------------------------------------------------------------
  // computation
  // ---------------------------------------------------------------
  logic [15:0] res_d, flt_d, err_d;
  logic [17:0] acc_d, sample;
  logic [7:0] cnt_d;
  logic rep_mode, check, below_d, above_d, irq_d;

  always_comb
  begin
    // right or left justified by the format bit
    res_d = ctrl_q.result_format_mode[0] ? {4'h0, I_CONV_DATA}
      : {I_CONV_DATA, 4'h0};
    sample = {{2{res_d[15]}}, res_d};
    case (ctrl_q.md)
      adc_cmp_pkg::MD_ACC, adc_cmp_pkg::MD_AVG, adc_cmp_pkg::MD_BURST:
        acc_d = acc_q + sample;
      adc_cmp_pkg::MD_LPF:
        acc_d = acc_q + sample - 18'($signed(acc_q) >>> ctrl_q.accum_shift);
      default: acc_d = acc_q;
    endcase
    flt_d = 16'($signed(acc_d) >>> ctrl_q.accum_shift);
    case (ctrl_q.error_mode_a)
      adc_cmp_pkg::ERROR_MODE_A_RES_PREV: err_d = res_d - prev_q;
      adc_cmp_pkg::ERROR_MODE_A_RES_STPT: err_d = res_d - stpt_q;
      adc_cmp_pkg::ERROR_MODE_A_RES_FLT: err_d = res_d - flt_d;
      default: err_d = flt_d - stpt_q;
    endcase
    rep_mode = ctrl_q.md == adc_cmp_pkg::MD_AVG
      || ctrl_q.md == adc_cmp_pkg::MD_BURST
      || ctrl_q.md == adc_cmp_pkg::MD_LPF;
    cnt_d = (cnt_q == adc_cmp_pkg::CNT_MAX) ? cnt_q : cnt_q + 8'h01;
    check = !rep_mode || cnt_d >= rpt_q;
    below_d = $signed(err_d) < $signed(lth_q);
    above_d = $signed(err_d) > $signed(uth_q);
    case (ctrl_q.threshold_irq_mode)
      adc_cmp_pkg::TMD_NEVER: irq_d = 1'b0;
      adc_cmp_pkg::TMD_BELOW: irq_d = below_d;
      adc_cmp_pkg::TMD_ABOVE: irq_d = above_d;
      adc_cmp_pkg::TMD_INSIDE: irq_d = !below_d && !above_d;
      adc_cmp_pkg::TMD_OUTSIDE: irq_d = below_d || above_d;
      adc_cmp_pkg::TMD_NOT_BELOW: irq_d = !below_d;
      adc_cmp_pkg::TMD_NOT_ABOVE: irq_d = !above_d;
      default: irq_d = 1'b1;
    endcase
  end

  assign wr_acc_ok = wr_ok && aw_idx_q == adc_cmp_pkg::IDX_ACC && !go_q;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      acc_q <= '0;
    end
    else if (I_CONV_DONE && go_q)
    begin
      acc_q <= acc_d;
    end
    else if (wr_acc_ok)
    begin
      acc_q <= 18'(upd({14'h0000, acc_q}));
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      res_q <= adc_cmp_pkg::RST_WORD16;
      flt_q <= adc_cmp_pkg::RST_WORD16;
      err_q <= adc_cmp_pkg::RST_WORD16;
      cnt_q <= '0;
    end
    else if (I_CONV_DONE && go_q)
    begin
      res_q <= res_d;
      flt_q <= flt_d;
      err_q <= err_d;
      cnt_q <= (rep_mode && check) ? 8'h00 : cnt_d;
    end
    else if (wr_ok && aw_idx_q == adc_cmp_pkg::IDX_CNT)
    begin
      cnt_q <= wm[7:0];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      below_q <= 1'b0;
      above_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= I_CONV_DONE && go_q && check && irq_d;
      if (I_CONV_DONE && go_q && check)
      begin
        below_q <= below_d;
        above_q <= above_d;
      end
    end
  end
  assign O_THRESH_IRQ = irq_q;
endmodule
`default_nettype wire

// [verif/adc_cmp_top_asserts.sv]
/*
  port-level checks of the converter control block.
  assumes one clock domain and the active-high asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_cmp_top_chk
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // register bus
  input wire logic O_AWREADY,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic [1:0] O_BRESP,
  input wire logic I_BREADY,
  input wire logic O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic I_RREADY,
  // converter and outputs
  input wire logic O_CONV_START,
  input wire logic I_CONV_DONE,
  input wire logic O_THRESH_IRQ,
  input wire logic [5:0] O_POS_CHANNEL,
  input wire adc_cmp_pkg::groups_t O_GROUPS
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  property p_one_start;
    O_CONV_START |=> !O_CONV_START;
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("second start while busy");
  property p_irq_done;
    O_THRESH_IRQ |-> $past(I_CONV_DONE);
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("threshold event without a finished conversion");
  property p_irq_pulse;
    O_THRESH_IRQ |=> !O_THRESH_IRQ;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("threshold event longer than one cycle");
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");
  property p_b_after;
    $rose(O_BVALID) |-> !$past(O_AWREADY) && !$past(O_WREADY);
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write response before address and data");
  property p_grp_cause;
    !$stable(O_GROUPS) |-> $rose(O_BVALID);
  endproperty
  a_grp_cause: assert property (p_grp_cause)
    else $error("group enables changed without a write");
  property p_chan_cause;
    !$stable(O_POS_CHANNEL) |-> $rose(O_BVALID);
  endproperty
  a_chan_cause: assert property (p_chan_cause)
    else $error("channel changed without a write");
endmodule
bind adc_cmp_top adc_cmp_top_chk adc_cmp_top_chk_i
(
  .I_REF_CLK, .I_RST, .O_AWREADY, .O_WREADY, .O_BVALID, .O_BRESP,
  .I_BREADY, .O_RVALID, .O_RDATA, .I_RREADY, .O_CONV_START,
  .I_CONV_DONE, .O_THRESH_IRQ, .O_POS_CHANNEL, .O_GROUPS
);
`default_nettype wire

// [verif/adc_conv_model.sv]
/*
  converter stand-in: answers each start pulse with one done pulse.
  assumes start is a one-cycle pulse on the shared clock.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_conv_model
(
  // clock and control
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [3:0] i_delay,
  input wire logic [11:0] i_sample,
  // answer
  output logic o_done,
  output logic [11:0] o_data
);
  int cnt = 0;
  initial o_done = 1'h0;
  initial o_data = 12'hA5A;
  always @(posedge i_clk)
  begin
    o_done <= 1'h0;
    // sample lines carry junk outside the done cycle
    o_data <= ~o_data;
    if (i_start)
      cnt <= i_delay + 1;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        o_done <= 1'h1;
        o_data <= i_sample;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
/*
  self-checking bench of the converter control block.
  assumes the converter stand-in and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // signals, tasks and sequence
  // ---------------------------------------------------------------
  logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0;
  logic arv = 1'h0, rr = 1'h0, pin = 1'h0, lo, hi;
  logic [15:0] aw = 16'h0, ar = 16'h0;
  logic [31:0] wd = 32'h0, peri = 32'h0, me, mm, v, rdat;
  logic [3:0] ws = 4'h0, dly = 4'h0;
  logic [11:0] smp = 12'h0, s, t, cdat;
  logic awr, wrdy, bv, arr, rv, start, done, irq;
  logic [1:0] bresp, rresp, rx, bq[$];
  logic [5:0] pch;
  logic [34:0] g = 35'h0;
  logic [65:0] eq[$];
  adc_cmp_pkg::groups_t grp;
  int n_fail = 0, samples_checked = 0, n_irq = 0, n_start = 0;
  int n_done = 0, seed = 48446;
  logic [13:0] rz[7] = '{adc_cmp_pkg::IDX_LTH, adc_cmp_pkg::IDX_UTH,
    adc_cmp_pkg::IDX_STPT, adc_cmp_pkg::IDX_CGA, adc_cmp_pkg::IDX_CGB,
    adc_cmp_pkg::IDX_CGC, adc_cmp_pkg::IDX_CGD};
  always #12.5 clk = ~clk;
  adc_cmp_top adc_cmp_top_i
  (
    .I_REF_CLK(clk), .I_RST(rst), .I_AWADDR(aw), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
    .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br),
    .I_ARADDR(ar), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat),
    .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr), .I_TRIG_PERIPH(peri),
    .I_TRIG_PIN(pin), .O_CONV_START(start), .I_CONV_DONE(done),
    .I_CONV_DATA(cdat), .O_POS_CHANNEL(pch), .O_GROUPS(grp),
    .O_THRESH_IRQ(irq)
  );
  adc_conv_model adc_conv_model_i
  (
    .i_clk(clk), .i_start(start), .i_delay(dly), .i_sample(smp),
    .o_done(done), .o_data(cdat)
  );
  task automatic results;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [39:0] gt, input logic [39:0] ex);
    samples_checked++;
    if (gt !== ex)
    begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h want %h", $time, gt, ex);
    end
  endtask
  task automatic guard(inout int k);
    k++;
    if (k > 200)
    begin
      n_fail++;
      $display("CHECK FAILED %0t: wait timed out", $time);
      results();
    end
  endtask
  task automatic wr(input logic [13:0] ix, input logic [31:0] d,
    input logic [3:0] sb, input logic [1:0] er);
    int k = 0;
    bq.push_back(er);
    aw <= {ix, 2'h0};
    wd <= d;
    ws <= sb;
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(posedge clk);
      guard(k);
      if (awr)
        awv <= 1'h0;
      if (wrdy)
        wv <= 1'h0;
    end while (awv || wv);
    @(posedge clk);
    br <= 1'h1;
    do
    begin
      @(posedge clk);
      guard(k);
    end while (!bv);
    br <= 1'h0;
  endtask
  task automatic rd(input logic [13:0] ix, input logic [31:0] e,
    input logic [31:0] m);
    int k = 0;
    eq.push_back({((ix == 14'h1D50) ? 2'h2 : 2'h0), e & m, m});
    ar <= {ix, 2'h0};
    arv <= 1'h1;
    do
    begin
      @(posedge clk);
      guard(k);
    end while (!arr);
    arv <= 1'h0;
    @(posedge clk);
    rr <= 1'h1;
    do
    begin
      @(posedge clk);
      guard(k);
    end while (!rv);
    rr <= 1'h0;
  endtask
  task automatic conv(input logic [31:0] c, input logic [11:0] x,
    input int ni, input logic poke);
    int k = 0;
    int i0 = n_irq;
    int d0 = n_done;
    smp <= x;
    dly <= poke ? 4'hF : 4'h3 & $random(seed);
    wr(adc_cmp_pkg::IDX_CTRL, c, 4'hF, 2'h0);
    wr(adc_cmp_pkg::IDX_CTRL, c | 32'h1, 4'hF, 2'h0);
    if (poke)
      wr(adc_cmp_pkg::IDX_ACC, 32'h1, 4'hF, 2'h0);
    while (n_done == d0)
    begin
      @(posedge clk);
      guard(k);
    end
    repeat (2) @(posedge clk);
    chk(n_irq - i0, ni);
  endtask
  task automatic trig(input int c, input logic en, input int ex);
    int s0;
    logic [31:0] r;
    r = $random(seed);
    wr(adc_cmp_pkg::IDX_CTRL, {30'h0, en, 1'h0}, 4'hF, 2'h0);
    wr(adc_cmp_pkg::IDX_ACT, c, 4'hF, 2'h0);
    s0 = n_start;
    peri <= r & ~(32'h1 << c);
    repeat (3) @(posedge clk);
    peri <= r | (32'h1 << c);
    pin <= 1'h1;
    repeat (4) @(posedge clk);
    wr(adc_cmp_pkg::IDX_PCH, c, 4'hF, 2'h0);
    rd(adc_cmp_pkg::IDX_RES, 32'h0, 32'h0);
    rd(adc_cmp_pkg::IDX_ERR, 32'h0, 32'h0);
    repeat (20) @(posedge clk);
    chk(n_start - s0, ex);
    chk(pch, c & 6'h3F);
    peri <= 32'h0;
    pin <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  function automatic int want(input int m, input logic l, input logic h);
    case (m)
      0: return 0;
      1: return l;
      2: return h;
      3: return !l && !h;
      4: return l || h;
      5: return !l;
      6: return !h;
      default: return 1;
    endcase
  endfunction
  // results appear here and are matched against the oldest note
  always @(posedge clk)
  begin
    n_irq += (irq === 1'h1);
    n_start += (start === 1'h1);
    n_done += (done === 1'h1);
    if (rv && rr)
    begin
      {rx, me, mm} = eq.pop_front();
      chk(rdat & mm, me);
      chk(rresp, rx);
    end
    if (bv && br)
      chk(bresp, bq.pop_front());
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    foreach (rz[i])
      rd(rz[i], 32'h0, 32'hFFFF);
    chk(grp, 35'h0);
    $display("reset values done");
    for (int i = 0; i < 5; i++)
    begin
      v = $random(seed);
      wr(adc_cmp_pkg::IDX_CGA + i, v, 4'hF, 2'h0);
      rd(adc_cmp_pkg::IDX_CGA + i, v & (i == 4 ? 8'h7 : 8'hFF), 32'hFF);
      g = g | ({27'h0, v[7:0]} << (8 * i));
    end
    chk(grp, g);
    wr(14'h1D50, 32'h1, 4'hF, 2'h2);
    rd(14'h1D50, 32'h0, 32'hFFFFFFFF);
    wr(adc_cmp_pkg::IDX_ACC, 32'h0002FFFF, 4'hF, 2'h0);
    rd(adc_cmp_pkg::IDX_ACC, 32'h00FEFFFF, 32'hFFFFFFFF);
    wr(adc_cmp_pkg::IDX_ACC, 32'h00005500, 4'h2, 2'h0);
    rd(adc_cmp_pkg::IDX_ACC, 32'h00FE55FF, 32'hFFFFFFFF);
    $display("register access done");
    s = $random(seed);
    t = $random(seed);
    conv(32'h0A, s, 0, 1'h0);
    rd(adc_cmp_pkg::IDX_RES, {20'h0, s}, 32'hFFFF);
    conv(32'h0A, t, 0, 1'h1);
    rd(adc_cmp_pkg::IDX_PREV, {20'h0, s}, 32'hFFFF);
    rd(adc_cmp_pkg::IDX_ERR, {20'h0, t} - s, 32'hFFFF);
    rd(adc_cmp_pkg::IDX_ACC, 32'h00FE55FF, 32'hFFFFFFFF);
    conv(32'h02, s, 0, 1'h0);
    conv(32'h02, t, 0, 1'h0);
    rd(adc_cmp_pkg::IDX_PREV, {16'h0, s, 4'h0}, 32'hFFFF);
    $display("basic conversion done");
    wr(adc_cmp_pkg::IDX_LTH, 32'hFF00, 4'hF, 2'h0);
    wr(adc_cmp_pkg::IDX_UTH, 32'h0100, 4'hF, 2'h0);
    wr(adc_cmp_pkg::IDX_STPT, 32'h0800, 4'hF, 2'h0);
    for (int m = 0; m < 8; m++)
    begin
      s = 12'h600 + 12'h200 * (m % 3);
      lo = (m % 3 == 0);
      hi = (m % 3 == 2);
      conv(32'h2A | (m << 8), s, want(m, lo, hi), 1'h0);
      rd(adc_cmp_pkg::IDX_ERR, {20'h0, s} - 32'h800, 32'hFFFF);
      rd(adc_cmp_pkg::IDX_STAT, {hi, lo}, 32'h3);
    end
    $display("thresholds done");
    s = $random(seed);
    wr(adc_cmp_pkg::IDX_ACC, 32'h0, 4'hF, 2'h0);
    conv(32'h480E, s, 0, 1'h0);
    rd(adc_cmp_pkg::IDX_FLT, {21'h0, s[11:1]}, 32'hFFFF);
    conv(32'h480E, t, 0, 1'h0);
    rd(adc_cmp_pkg::IDX_PREV, {21'h0, s[11:1]}, 32'hFFFF);
    rd(adc_cmp_pkg::IDX_ACC, s + {20'h0, t}, 32'h3FFFF);
    wr(adc_cmp_pkg::IDX_RPT, 32'h2, 4'hF, 2'h0);
    wr(adc_cmp_pkg::IDX_CNT, 32'h0, 4'hF, 2'h0);
    conv(32'h1070A, s, 0, 1'h0);
    conv(32'hC70A, t, 1, 1'h0);
    $display("filter modes done");
    for (int c = 0; c < 32; c++)
      trig(c, 1'h1, (c == 0 || (c > 25 && c < 29)) ? 0 : 1);
    trig(2, 1'h0, 0);
    $display("triggers done");
    results();
  end
endmodule
`default_nettype wire
